// ==== rtl/urs_cfg.svh ====
// constants for the uart receive status block
`ifndef URS_CFG_SVH
`define URS_CFG_SVH
`define URS_STA_OFF 8'h00
`define URS_MASK_OFF 8'h04
`define URS_IRQ_OFF 8'h08
`define URS_DATA_OFF 8'h0c
`define URS_B_RXDA 0
`define URS_B_RX_OVERRUN_FLAG 1
`define URS_B_FRAMING_ERROR_FLAG 2
`define URS_B_PARITY_ERROR_FLAG 3
`define URS_B_IDLE 4
`define URS_B_ADDR_CHAR_DETECT_ENABLE 5
`define URS_B_SEL_LO 6
`define URS_B_NINE 8
`define URS_IRQ_W 3
`define URS_I_THR 0
`define URS_I_OVR 1
`define URS_I_ERR 2
`define URS_RESP_OK 2'b00
`define URS_RESP_ERR 2'b10
`define URS_ZERO32 32'h0000_0000
`endif

// ==== rtl/urs_pkg.sv ====
// types for the uart receive status block
package urs_pkg;
  typedef enum logic [1:0] {
    URS_SEL_ANY,
    URS_SEL_HALF,
    URS_SEL_3Q,
    URS_SEL_RSVD
  } urs_sel_t;
  typedef struct packed {
    logic [8:0] data;
    logic parity_err;
    logic framing_err;
  } urs_char_t;
endpackage

// ==== rtl/urs_rx_status.sv ====
// uart receive status, buffer, threshold irq and axi4-lite registers
//
// Overview of operation
// - selector 00 raises the receive flag while the buffer holds a char.
// - selector 01 raises the receive flag while half full or fuller.
// - selector 10 raises the receive flag while 3/4 full or fuller.
// - with address detect on in 9-bit mode only bit-8 chars are taken.
// - the idle flag reads one unless a character is being received.
// - the parity flag shows the parity error of the current char.
// - the framing flag shows the framing error of the current char.
// - the overrun flag is set when the receive buffer overflows.
// - only hardware sets the overrun flag, only a written zero clears it.
// - clearing a set overrun flag empties buffer and shift register.
// - the data flag reads one while the buffer holds a character.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "urs_cfg.svh"
module urs_rx_status #(
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rx_busy,
  input wire logic rx_char_valid,
  input wire urs_pkg::urs_char_t rx_char,
  input wire logic nine_bit_mode,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic rx_irq_flag,
  output logic rx_shift_clear,
  output logic irq
);
  import urs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // the fill count relies on wrapping pointers, so only powers of two
  // work, and the 1/2 and 3/4 marks need at least four entries
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 4");
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  urs_sel_t rx_irq_threshold_sel;
  logic addr_char_detect_enable;
  logic rx_overrun_flag;
  logic [`URS_IRQ_W-1:0] irq_status;
  logic [`URS_IRQ_W-1:0] irq_mask;

  // ---------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------
  urs_char_t mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire [AW:0] fill = wr_ptr - rd_ptr;
  wire buf_full = fill[AW];
  wire buf_empty = (fill == '0);
  wire urs_char_t head = mem[rd_ptr[AW-1:0]];

  // address chars only when both enable and 9-bit mode are on
  wire addr_filter = addr_char_detect_enable & nine_bit_mode;
  wire char_ok = !addr_filter || rx_char.data[`URS_B_NINE];
  wire push_req = rx_char_valid && char_ok && !rx_overrun_flag;
  wire overflow = push_req && buf_full;
  wire push = push_req && !buf_full;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_sta = wr_go && aw_addr == `URS_STA_OFF;
  wire wr_mask = wr_go && aw_addr == `URS_MASK_OFF;
  wire wr_hit = wr_sta || wr_mask || (wr_go && (aw_addr == `URS_IRQ_OFF
    || aw_addr == `URS_DATA_OFF));
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire rd_sta = s_axi_araddr == `URS_STA_OFF;
  wire rd_mask = s_axi_araddr == `URS_MASK_OFF;
  wire rd_irq = s_axi_araddr == `URS_IRQ_OFF;
  wire rd_data = s_axi_araddr == `URS_DATA_OFF;
  wire rd_hit = rd_sta || rd_mask || rd_irq || rd_data;
  wire pop = rd_go && rd_data && !buf_empty;
  wire lane0 = w_strb[0];
  wire lane0_ok = wr_sta && lane0;
  // a written zero over a set flag is the only clear; overflow wins
  wire rx_overrun_flag_clear = lane0_ok && rx_overrun_flag &&
    !w_data[`URS_B_RX_OVERRUN_FLAG] && !overflow;
  wire flush = rx_overrun_flag_clear;

  // ---------------------------------------------------------------
  // threshold and status
  // ---------------------------------------------------------------
  wire [AW:0] half = (AW + 1)'(DEPTH / 2);
  wire [AW:0] three_q = (AW + 1)'((DEPTH * 3) / 4);
  logic thr_hit;
  always_comb begin
    case (rx_irq_threshold_sel)
      URS_SEL_ANY: thr_hit = !buf_empty;
      URS_SEL_HALF: thr_hit = fill >= half;
      URS_SEL_3Q: thr_hit = fill >= three_q;
      // reserved code: treat as not-empty so the flag stays sane
      default: thr_hit = !buf_empty;
    endcase
  end

  wire parity_error_flag_now = !buf_empty && head.parity_err;
  wire framing_error_flag_now = !buf_empty && head.framing_err;
  wire idle_now = !rx_busy;
  wire [31:0] sta_word = {24'h0, rx_irq_threshold_sel,
    addr_char_detect_enable, idle_now, parity_error_flag_now, framing_error_flag_now,
    rx_overrun_flag, !buf_empty};
  wire [`URS_IRQ_W-1:0] events = {parity_error_flag_now | framing_error_flag_now, overflow,
    thr_hit & !rx_irq_flag};
  wire irq_clr = rd_go && rd_irq;
  wire [`URS_IRQ_W-1:0] next_irq_status;
  // a clearing read and a new event in one cycle: the event stays set
  for (genvar gi = 0; gi < `URS_IRQ_W; gi++) begin : g_irq_bit
    assign next_irq_status[gi] = events[gi] | (!irq_clr & irq_status[gi]);
  end
  wire next_irq = |(next_irq_status & irq_mask);
  wire [31:0] rd_word = rd_sta ? sta_word :
    rd_mask ? {29'h0, irq_mask} :
    rd_irq ? {29'h0, irq_status} :
    rd_data ? {23'h0, head.data} : `URS_ZERO32;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= rx_char;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_overrun_flag <= 1'b0;
    end else if (overflow) begin
      rx_overrun_flag <= 1'b1;
    end else if (rx_overrun_flag_clear) begin
      rx_overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_irq_threshold_sel <= URS_SEL_ANY;
      addr_char_detect_enable <= 1'b0;
      irq_mask <= '0;
    end else begin
      if (lane0_ok) begin
        rx_irq_threshold_sel <=
          urs_sel_t'(w_data[`URS_B_SEL_LO +: 2]);
        addr_char_detect_enable <= w_data[`URS_B_ADDR_CHAR_DETECT_ENABLE];
      end
      if (wr_mask && lane0) irq_mask <= w_data[`URS_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end

  // the threshold flag is one cycle behind the fill count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_irq_flag <= 1'b0;
      rx_shift_clear <= 1'b0;
    end else begin
      rx_irq_flag <= thr_hit;
      rx_shift_clear <= flush;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  // address and data are taken in either order and parked until the
  // response is accepted, so at most one write is ever in flight
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire next_awready = b_done || (!aw_held && !aw_take);
  wire next_wready = b_done || (!w_held && !w_take);
  wire [1:0] next_bresp = wr_hit ? `URS_RESP_OK : `URS_RESP_ERR;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= next_awready;
      if (b_done) begin
        aw_held <= 1'b0;
      end else if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= next_wready;
      if (b_done) begin
        w_held <= 1'b0;
      end else if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `URS_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_bresp;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  // a new address is refused while the last answer is still standing
  wire r_done = s_axi_rvalid && s_axi_rready;
  wire next_arready = !rd_go && (r_done || !s_axi_rvalid);
  wire [1:0] next_rresp = rd_hit ? `URS_RESP_OK : `URS_RESP_ERR;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= next_arready;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
      end else if (r_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // data and response only move when a read is taken, so they stand
  // unchanged for as long as the master stalls the answer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rdata <= `URS_ZERO32;
      s_axi_rresp <= `URS_RESP_OK;
    end else if (rd_go) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule

// ==== verification/urs_rx_status_assertions.sv ====
// port assertions for the receive status block
`timescale 1ns/100ps
module urs_rx_status_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic rx_shift_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while answering");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'b00 |->
    s_axi_rdata == 32'h0) else $error("error read carries data");
  a_clr_pulse: assert property (
    rx_shift_clear |=> !rx_shift_clear)
    else $error("shift clear longer than one cycle");
endmodule

// ==== verification/urs_tx_model.sv ====
// remote serial transmitter model feeding received characters
`timescale 1ns/100ps
module urs_tx_model (
  input wire logic clk,
  output logic rx_busy,
  output logic rx_char_valid,
  output urs_pkg::urs_char_t rx_char
);
  import urs_pkg::*;
  initial begin
    rx_busy = 1'b0;
    rx_char_valid = 1'b0;
    rx_char = '0;
  end
  // a character occupies the line ten cycles before it is offered
  task automatic send(input logic [8:0] v, input logic pe, input logic fe);
    @(posedge clk);
    rx_busy <= 1'b1;
    repeat (10) @(posedge clk);
    rx_busy <= 1'b0;
    rx_char_valid <= 1'b1;
    rx_char <= {v, pe, fe};
    @(posedge clk);
    rx_char_valid <= 1'b0;
    // released data must not look like a held character
    rx_char <= ~{v, pe, fe};
  endtask
endmodule

// ==== verification/test_urs_rx_status.sv ====
// self-checking bench for the receive status block
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_urs_rx_status;
  import urs_pkg::*;
  logic clk = 0, reset_n = 0, nine_bit_mode = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_busy, rx_char_valid, rx_irq_flag, rx_shift_clear;
  logic irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  urs_char_t rx_char;
  int fails = 0, comparisons = 0, clears = 0;
  urs_rx_status #(.DEPTH(4)) i_urs_rx_status (.*);
  urs_tx_model i_urs_tx_model (.*);
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (rx_shift_clear) clears++;
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] re = 2'b00, input logic [3:0] st = 4'hf);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", re, s_axi_bresp)
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
    input logic [31:0] e, input logic [1:0] re = 2'b00);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    `CHK(n, e, d)
    `CHK("rresp", re, s_axi_rresp)
  endtask
  task automatic fchk(input string n, input logic e);
    repeat (2) @(posedge clk);
    `CHK(n, e, (n == "irq") ? irq : rx_irq_flag)
  endtask
  task automatic tx(input logic [8:0] v, input logic pe, input logic fe);
    i_urs_tx_model.send(v, pe, fe);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // selector writes use 00, 01 and 10 only
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    rchk("idle", 8'h00, 32'h10);
    fork
      tx(9'h055, 1'b1, 1'b0);
      begin
        repeat (3) @(posedge clk);
        rchk("busy", 8'h00, 32'h00);
      end
    join
    fchk("flag", 1'b1);
    rchk("parity_error_flag", 8'h00, 32'h19);
    tx(9'h0a3, 1'b0, 1'b1);
    rchk("pop", 8'h0c, 32'h55);
    rchk("framing_error_flag", 8'h00, 32'h15);
    wr(8'h00, 32'h40);
    fchk("flag", 1'b0);
    tx(9'h001, 1'b0, 1'b0);
    fchk("flag", 1'b1);
    wr(8'h00, 32'h80);
    fchk("flag", 1'b0);
    tx(9'h002, 1'b0, 1'b0);
    fchk("flag", 1'b1);
    tx(9'h003, 1'b0, 1'b0);
    tx(9'h004, 1'b0, 1'b0);
    rchk("ovr", 8'h00, 32'h97);
    wr(8'h00, 32'h82);
    rchk("ovr1", 8'h00, 32'h97);
    wr(8'h00, 32'h80);
    rchk("flush", 8'h00, 32'h90);
    `CHK("clears", 1, clears)
    fchk("irq", 1'b0);
    wr(8'h04, 32'h2);
    fchk("irq", 1'b1);
    rchk("irqsta", 8'h08, 32'h7);
    fchk("irq", 1'b0);
    rchk("irqsta", 8'h08, 32'h0);
    wr(8'h00, 32'h20);
    // byte lane 0 off: this write must leave address detect enabled
    wr(8'h00, 32'h0, 2'b00, 4'he);
    nine_bit_mode <= 1'b1;
    tx(9'h011, 1'b0, 1'b0);
    tx(9'h1aa, 1'b0, 1'b0);
    rchk("addr", 8'h0c, 32'h1aa);
    rchk("addrsta", 8'h00, 32'h30);
    nine_bit_mode <= 1'b0;
    tx(9'h011, 1'b0, 1'b0);
    rchk("eight", 8'h0c, 32'h011);
    rchk("unmapped", 8'h10, 32'h0, 2'b10);
    wr(8'h10, 32'h0, 2'b10);
    report_and_stop();
  end
endmodule
bind urs_rx_status urs_rx_status_checker i_urs_rx_status_checker (.*);
